//--- pkg/cdt_map.svh
// Operation
// - Two 8-bit read/write up-counters, reset zero
// - Clock select plus internal select pick source
// - Clear by external reset, match A, B
// - Compare A register resets FF, sets flag A
// - Compare B register resets FF, sets flag B
// - Match A drives pin per low select bits
// - Match B drives pin per high select bits
// - Clock select 100 chains counters to 16 bits
// - Chained upper counter counts lower overflows
// - Chained upper flags need full 16-bit match
// - Chained lower flags follow lower byte match
// - Chained match clear clears both bytes together
// - Chained external-reset select still clears on 16-bit match A
// - Chained mode ignores lower counter clear field
// - Chained pin 0 follows 16-bit matches
// - Chained pin 1 follows lower-byte matches
// - Clear on A gives period value plus one
// - Control enables external reset requests
// - Clear field 01 clears on match A
// - Output select 01 on B drives low
// - Output select 10 on A drives high
// - Select 001 with 00 counts clock/8 rising
`ifndef CDT_MAP_SVH
`define CDT_MAP_SVH

// Register word indices; byte address is index times four
`define CDT_IDX_CTRL0    4'h0
`define CDT_IDX_CTRL1    4'h1
`define CDT_IDX_STAT0    4'h2
`define CDT_IDX_STAT1    4'h3
`define CDT_IDX_CMPA0    4'h4
`define CDT_IDX_CMPA1    4'h5
`define CDT_IDX_CMPB0    4'h6
`define CDT_IDX_CMPB1    4'h7
`define CDT_IDX_CNT0     4'h8
`define CDT_IDX_CNT1     4'h9
`define CDT_IDX_CCTL0    4'ha
`define CDT_IDX_CCTL1    4'hb
`define CDT_IDX_LAST     4'hb
// First byte-address bit above the register window
`define CDT_ADDR_TOP     6

// Reset values
`define CDT_CNT_RST      8'h00
`define CDT_CMP_RST      8'hff
`define CDT_REG_RST      8'h00
`define CDT_CNT_MAX      8'hff

// Timer control register fields
`define CDT_CKS_LSB      0
`define CDT_CKS_MSB      2
`define CDT_CCLR_LSB     3
`define CDT_CCLR_MSB     4
`define CDT_CTRL_MASK    8'hff

// Counter control register fields
`define CDT_ICKS_LSB     0
`define CDT_ICKS_MSB     1
`define CDT_EXTEN_BIT    2
`define CDT_CCTL_MASK    8'h07

// Control/status register fields
`define CDT_OSA_LSB      0
`define CDT_OSA_MSB      1
`define CDT_OSB_LSB      2
`define CDT_OSB_MSB      3
`define CDT_FLAGA_BIT    6
`define CDT_FLAGB_BIT    7
`define CDT_STAT_MASK    8'h0f

// Encodings
`define CDT_CKS_OFF      3'b000
`define CDT_CKS_FAST     3'b001
`define CDT_CKS_MID      3'b010
`define CDT_CKS_SLOW     3'b011
`define CDT_CKS_CHAIN    3'b100
`define CDT_CLR_NONE     2'b00
`define CDT_CLR_A        2'b01
`define CDT_CLR_B        2'b10
`define CDT_CLR_EXT      2'b11
`define CDT_OS_KEEP      2'b00
`define CDT_OS_LOW       2'b01
`define CDT_OS_HIGH      2'b10
`define CDT_OS_TOGGLE    2'b11

// Prescaler taps: bit k of the free counter is clock/2^(k+1)
`define CDT_PRESC_W      13
`define CDT_TAP_DIV2     0
`define CDT_TAP_DIV8     2
`define CDT_TAP_DIV32    4
`define CDT_TAP_DIV64    5
`define CDT_TAP_DIV1024  9
`define CDT_TAP_DIV8192  12

`endif

//--- pkg/cdt_pkg.sv
`include "cdt_map.svh"

package cdt_pkg;

	typedef logic [7:0] cdt_byte_t;

	// Whole state of the timer unit, index 0 upper, index 1 lower
	typedef struct packed {
		logic [1:0][7:0]           cnt;
		logic [1:0][7:0]           cmpa;
		logic [1:0][7:0]           cmpb;
		logic [1:0][7:0]           ctrl;
		logic [1:0][7:0]           cctl;
		logic [1:0][3:0]           osel;
		logic [1:0]                flaga;
		logic [1:0]                flagb;
		logic [1:0]                mpa;
		logic [1:0]                mpb;
		logic [1:0]                pin;
		logic [`CDT_PRESC_W-1:0]   presc;
		logic [2:0]                sync;
		logic                      ext_lvl;
		logic [31:0]               rdata;
		logic                      ready;
		logic                      slverr;
	} cdt_state_s;

endpackage

//--- logic/cdt_timer.sv
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "cdt_map.svh"

module cdt_timer #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              CLOCK,
	input  wire logic              RSTN,
	// APB slave
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic [31:0]            PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	// Pins
	input  wire logic              EXTERNAL_COUNTER_RESET_PIN,
	output logic                   COMPARE_OUTPUT_PIN_0,
	output logic                   COMPARE_OUTPUT_PIN_1
);

	// Word decode needs address bits up to 5
	if (ADDR_W < 6) begin : g_bad_addr
		$error("cdt_timer: ADDR_W must be at least 6");
	end

	cdt_pkg::cdt_state_s st;
	cdt_pkg::cdt_state_s next_st;

	logic [1:0] tick;
	logic [1:0] ma;
	logic [1:0] mb;
	logic [1:0] ev_a;
	logic [1:0] ev_b;
	logic [1:0] clr;
	logic       chained;
	logic       ovf;
	logic       clr16;

	// Rising or falling edge of one prescaler tap, seen the cycle it happens
	function automatic logic tap_edge(input logic [`CDT_PRESC_W-1:0] p, input int k, input logic fall);
		logic [`CDT_PRESC_W-1:0] low;
		low = (`CDT_PRESC_W'(1) << k) - `CDT_PRESC_W'(1);
		tap_edge = ((p & low) == '0) && (p[k] != fall);
	endfunction

	// Count event for one timer from its selects; chained source handled apart
	function automatic logic pick_tick(input logic [`CDT_PRESC_W-1:0] p, input logic [2:0] cks,
		input logic [1:0] icks);
		logic fall;
		fall = icks[1];
		case (cks)
			`CDT_CKS_FAST: pick_tick = tap_edge(p, icks[0] ? `CDT_TAP_DIV2 : `CDT_TAP_DIV8, fall);
			`CDT_CKS_MID:  pick_tick = tap_edge(p, icks[0] ? `CDT_TAP_DIV32 : `CDT_TAP_DIV64, fall);
			`CDT_CKS_SLOW: pick_tick = tap_edge(p, icks[0] ? `CDT_TAP_DIV1024 : `CDT_TAP_DIV8192, fall);
			default:       pick_tick = 1'b0;
		endcase
	endfunction

	// Timer, match and clear logic plus the register port
	always_comb begin
		logic [3:0]  idx;
		logic        setup;
		logic        wr;
		logic [7:0]  wb;
		logic [1:0]  clrsel;
		logic [1:0]  os;
		logic        bad;
		clrsel  = 2'b00;
		os      = 2'b00;
		next_st = st;
		idx     = PADDR[5:2];
		setup   = PSEL && !PENABLE;
		wr      = PSEL && PENABLE && PWRITE && st.ready && !st.slverr;
		wb      = PWDATA[7:0];
		// Address bits above the window must be zero, or the word would alias a register
		bad     = (PADDR >> `CDT_ADDR_TOP) != '0 || PADDR[5:2] > `CDT_IDX_LAST || PADDR[1:0] != 2'b00;
		chained = st.ctrl[0][`CDT_CKS_MSB:`CDT_CKS_LSB] == `CDT_CKS_CHAIN;

		// Pin synchroniser: level changes only when stages two and three agree
		next_st.sync = {st.sync[1:0], EXTERNAL_COUNTER_RESET_PIN};
		if (st.sync[1] == st.sync[2]) begin
			next_st.ext_lvl = st.sync[2];
		end
		next_st.presc = st.presc + `CDT_PRESC_W'(1);

		// Compare: chained upper byte compares the full 16-bit value
		for (int i = 0; i < 2; i++) begin
			ma[i]   = st.cnt[i] == st.cmpa[i];
			mb[i]   = st.cnt[i] == st.cmpb[i];
			tick[i] = pick_tick(st.presc, st.ctrl[i][`CDT_CKS_MSB:`CDT_CKS_LSB],
				st.cctl[i][`CDT_ICKS_MSB:`CDT_ICKS_LSB]);
		end
		if (chained) begin
			ma[0] = {st.cnt[0], st.cnt[1]} == {st.cmpa[0], st.cmpa[1]};
			mb[0] = {st.cnt[0], st.cnt[1]} == {st.cmpb[0], st.cmpb[1]};
		end
		ev_a = ma & ~st.mpa;
		ev_b = mb & ~st.mpb;
		next_st.mpa = ma;
		next_st.mpb = mb;

		// Lower byte wraps once per count event at all ones
		ovf = tick[1] && st.cnt[1] == `CDT_CNT_MAX;

		// Clear request per timer, taken at that timer's next count event
		for (int i = 0; i < 2; i++) begin
			clrsel = st.ctrl[i][`CDT_CCLR_MSB:`CDT_CCLR_LSB];
			case (clrsel)
				`CDT_CLR_A: clr[i] = ma[i];
				`CDT_CLR_B: clr[i] = mb[i];
				`CDT_CLR_EXT: clr[i] = 1'b0;
				default: clr[i] = 1'b0;
			endcase
		end

		if (chained) begin
			// External select still clears on the 16-bit match A
			if (st.ctrl[0][`CDT_CCLR_MSB:`CDT_CCLR_LSB] == `CDT_CLR_EXT) begin
				clr[0] = ma[0];
			end
			clr16 = (tick[1] && clr[0])
				|| (st.ctrl[0][`CDT_CCLR_MSB:`CDT_CCLR_LSB] == `CDT_CLR_EXT
				&& st.cctl[0][`CDT_EXTEN_BIT] && st.ext_lvl);
			// Lower clear field plays no part here
			if (clr16) begin
				next_st.cnt[0] = `CDT_CNT_RST;
				next_st.cnt[1] = `CDT_CNT_RST;
			end else begin
				if (tick[1]) begin
					next_st.cnt[1] = st.cnt[1] + 8'h01;
				end
				if (ovf) begin
					next_st.cnt[0] = st.cnt[0] + 8'h01;
				end
			end
		end else begin
			clr16 = 1'b0;
			for (int i = 0; i < 2; i++) begin
				// External reset holds the counter at zero while the pin is high
				if (st.ctrl[i][`CDT_CCLR_MSB:`CDT_CCLR_LSB] == `CDT_CLR_EXT
					&& st.cctl[i][`CDT_EXTEN_BIT] && st.ext_lvl) begin
					next_st.cnt[i] = `CDT_CNT_RST;
				end else if (tick[i] && clr[i]) begin
					next_st.cnt[i] = `CDT_CNT_RST;
				end else if (tick[i]) begin
					next_st.cnt[i] = st.cnt[i] + 8'h01;
				end
			end
		end

		// Output pins: B applied first, then A acts on B's result when both match together
		for (int i = 0; i < 2; i++) begin
			if (ev_b[i]) begin
				os = st.osel[i][`CDT_OSB_MSB:`CDT_OSB_LSB];
				case (os)
					`CDT_OS_LOW:    next_st.pin[i] = 1'b0;
					`CDT_OS_HIGH:   next_st.pin[i] = 1'b1;
					`CDT_OS_TOGGLE: next_st.pin[i] = !st.pin[i];
					default:        next_st.pin[i] = st.pin[i];
				endcase
			end
			if (ev_a[i]) begin
				os = st.osel[i][`CDT_OSA_MSB:`CDT_OSA_LSB];
				case (os)
					`CDT_OS_LOW:    next_st.pin[i] = 1'b0;
					`CDT_OS_HIGH:   next_st.pin[i] = 1'b1;
					`CDT_OS_TOGGLE: next_st.pin[i] = !next_st.pin[i];
					default:        next_st.pin[i] = next_st.pin[i];
				endcase
			end
		end

		// Register writes take effect at the access edge and beat the count
		if (wr) begin
			case (idx)
				`CDT_IDX_CTRL0, `CDT_IDX_CTRL1: next_st.ctrl[idx[0]] = wb & `CDT_CTRL_MASK;
				`CDT_IDX_CCTL0, `CDT_IDX_CCTL1: next_st.cctl[idx[0]] = wb & `CDT_CCTL_MASK;
				`CDT_IDX_CMPA0, `CDT_IDX_CMPA1: next_st.cmpa[idx[0]] = wb;
				`CDT_IDX_CMPB0, `CDT_IDX_CMPB1: next_st.cmpb[idx[0]] = wb;
				`CDT_IDX_CNT0, `CDT_IDX_CNT1:   next_st.cnt[idx[0]]  = wb;
				`CDT_IDX_STAT0, `CDT_IDX_STAT1: begin
					next_st.osel[idx[0]] = wb[`CDT_OSB_MSB:`CDT_OSA_LSB];
					// Writing zero clears a flag; writing one leaves it
					if (!wb[`CDT_FLAGA_BIT]) begin
						next_st.flaga[idx[0]] = 1'b0;
					end
					if (!wb[`CDT_FLAGB_BIT]) begin
						next_st.flagb[idx[0]] = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// Flags are set after the clear so a match in the same cycle survives
		next_st.flaga = next_st.flaga | ev_a;
		next_st.flagb = next_st.flagb | ev_b;

		// Read data captured in the setup cycle; ready answers in the access cycle
		next_st.ready  = setup;
		next_st.slverr = setup && bad;
		if (setup) begin
			next_st.rdata = 32'h0000_0000;
			case (idx)
				`CDT_IDX_CTRL0, `CDT_IDX_CTRL1: next_st.rdata[7:0] = st.ctrl[idx[0]];
				`CDT_IDX_CCTL0, `CDT_IDX_CCTL1: next_st.rdata[7:0] = st.cctl[idx[0]];
				`CDT_IDX_CMPA0, `CDT_IDX_CMPA1: next_st.rdata[7:0] = st.cmpa[idx[0]];
				`CDT_IDX_CMPB0, `CDT_IDX_CMPB1: next_st.rdata[7:0] = st.cmpb[idx[0]];
				`CDT_IDX_CNT0, `CDT_IDX_CNT1:   next_st.rdata[7:0] = st.cnt[idx[0]];
				`CDT_IDX_STAT0, `CDT_IDX_STAT1: begin
					next_st.rdata[3:0]            = st.osel[idx[0]];
					next_st.rdata[`CDT_FLAGA_BIT] = st.flaga[idx[0]];
					next_st.rdata[`CDT_FLAGB_BIT] = st.flagb[idx[0]];
				end
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
		// Refused transfers read as zero
		if (next_st.slverr) begin
			next_st.rdata = 32'h0000_0000;
		end
	end

	// State register; all resets are constants
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			st.cnt     <= {`CDT_CNT_RST, `CDT_CNT_RST};
			st.cmpa    <= {`CDT_CMP_RST, `CDT_CMP_RST};
			st.cmpb    <= {`CDT_CMP_RST, `CDT_CMP_RST};
			st.ctrl    <= {`CDT_REG_RST, `CDT_REG_RST};
			st.cctl    <= {`CDT_REG_RST, `CDT_REG_RST};
			st.osel    <= '0;
			st.flaga   <= '0;
			st.flagb   <= '0;
			st.mpa     <= '0;
			st.mpb     <= '0;
			st.pin     <= '0;
			st.presc   <= '0;
			st.sync    <= '0;
			st.ext_lvl <= 1'b0;
			st.rdata   <= 32'h0000_0000;
			st.ready   <= 1'b0;
			st.slverr  <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state flops
	assign PRDATA               = st.rdata;
	assign PREADY               = st.ready;
	assign PSLVERR              = st.slverr;
	assign COMPARE_OUTPUT_PIN_0 = st.pin[0];
	assign COMPARE_OUTPUT_PIN_1 = st.pin[1];

endmodule

//--- verif/cdt_timer_assertions.sv
`timescale 1ns/10ps
module cdt_chk #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic              CLOCK,
	input wire logic              RSTN,
	// Bus
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic              PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0]       PWDATA,
	input wire logic [31:0]       PRDATA,
	input wire logic              PREADY,
	input wire logic              PSLVERR,
	// Pins
	input wire logic              EXTERNAL_COUNTER_RESET_PIN,
	input wire logic              COMPARE_OUTPUT_PIN_0,
	input wire logic              COMPARE_OUTPUT_PIN_1
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RSTN);
	logic aged;
	// Low in reset and at the first edge after reset release
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			aged <= 1'b0;
		else
			aged <= 1'b1;
	end
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_answer;
		PREADY ##1 !PREADY;
	endsequence
	a_apb_walk: assert property (s_setup |=> s_answer)
		else $error("ready not one cycle after setup");
	a_ready_cause: assert property (!(PSEL && !PENABLE) |=> !PREADY)
		else $error("ready without setup");
	a_high_bytes_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h00_0000)
		else $error("read data above byte not zero");
	a_misaligned_err: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=> PSLVERR && PRDATA == '0)
		else $error("misaligned access not refused");
	a_unmapped_err: assert property (PSEL && !PENABLE && PADDR[ADDR_W-1:2] > 11 |=> PSLVERR)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (PSEL && !PENABLE && PADDR[1:0] == 2'h0 && PADDR[ADDR_W-1:2] <= 11 |=> !PSLVERR)
		else $error("mapped access refused");
	a_rdata_held: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
		else $error("read data moved without setup");
	a_pins_reset: assert property (!aged |-> !COMPARE_OUTPUT_PIN_0 && !COMPARE_OUTPUT_PIN_1)
		else $error("pins not low after reset");
endmodule

bind cdt_timer cdt_chk #(.ADDR_W(ADDR_W)) u_chk (.CLOCK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
	.PRDATA, .PREADY, .PSLVERR, .EXTERNAL_COUNTER_RESET_PIN, .COMPARE_OUTPUT_PIN_0, .COMPARE_OUTPUT_PIN_1);

//--- verif/cdt_load.sv
`timescale 1ns/10ps
module cdt_load (
	// Clock and watched pins
	input wire logic CLOCK,
	input wire logic pin_0,
	input wire logic pin_1,
	// Reset level asked by the bench
	input wire logic ext_req,
	output logic     ext_pin
);
	int   run_0 = 0;
	int   run_1 = 0;
	int   high_0 = 0;
	int   low_0 = 0;
	int   gap_1 = 0;
	logic last_0 = 1'b0;
	logic last_1 = 1'b0;
	initial ext_pin = 1'b0;
	// Sees levels only, so it measures stretches between edges
	always @(posedge CLOCK) begin
		ext_pin <= ext_req;
		last_0 <= pin_0;
		last_1 <= pin_1;
		run_0 <= (pin_0 != last_0) ? 1 : run_0 + 1;
		run_1 <= (pin_1 != last_1) ? 1 : run_1 + 1;
		if (pin_0 && !last_0)
			low_0 <= run_0;
		if (!pin_0 && last_0)
			high_0 <= run_0;
		if (pin_1 != last_1)
			gap_1 <= run_1;
	end
endmodule

//--- verif/tb_cascaded_dual_byte_timer.sv
`timescale 1ns/10ps
`include "cdt_map.svh"
module tb_cascaded_dual_byte_timer;
	logic        CLOCK = 1'b0;
	logic        RSTN = 1'b0;
	logic        PSEL = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0000_0000;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic        ext_req = 1'b0;
	logic        ext_pin;
	logic        pin_0;
	logic        pin_1;
	int          err_total = 0;
	int          num_checks = 0;
	// 25 MHz
	always #20 CLOCK = ~CLOCK;
	cdt_timer dut (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.EXTERNAL_COUNTER_RESET_PIN(ext_pin), .COMPARE_OUTPUT_PIN_0(pin_0), .COMPARE_OUTPUT_PIN_1(pin_1));
	cdt_load u_load (.CLOCK(CLOCK), .pin_0(pin_0), .pin_1(pin_1), .ext_req(ext_req), .ext_pin(ext_pin));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [7:0] ad(input logic [3:0] i);
		return {2'h0, i, 2'h0};
	endfunction
	// One transfer; the request stands until ready is sampled, then one idle cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee = 1'b0);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		chk("slave error", {31'h0000_0000, ee}, {31'h0000_0000, PSLVERR});
		if (!w)
			chk("read data", d, PRDATA);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask
	task automatic end_of_test;
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// A hang counts as a mismatch
	initial begin
		repeat (6000) @(posedge CLOCK);
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge CLOCK);
		RSTN <= 1'b1;
		@(posedge CLOCK);
		// Reset values, then write and read back compares and counters
		for (int i = 4; i < 10; i++) begin
			acc(1'b0, ad(4'(i)), (i < 8) ? 32'h0000_00ff : 32'h0000_0000);
			acc(1'b1, ad(4'(i)), 32'h0000_005a);
			acc(1'b0, ad(4'(i)), 32'h0000_005a);
		end
		// Refused places; the misaligned write must be dropped
		acc(1'b1, 8'h11, 32'h0000_0011, 1'b1);
		acc(1'b0, 8'h30, 32'h0000_0000, 1'b1);
		acc(1'b0, ad(`CDT_IDX_CMPA0), 32'h0000_005a);
		// Lower timer alone: clock/8, clear on A at 3, toggle gives 4 counts of 8
		acc(1'b1, ad(`CDT_IDX_CNT1), 32'h0000_0000);
		acc(1'b1, ad(`CDT_IDX_CMPA1), 32'h0000_0003);
		acc(1'b1, ad(`CDT_IDX_STAT1), 32'h0000_0003);
		acc(1'b1, ad(`CDT_IDX_CTRL1), 32'h0000_0009);
		repeat (200) @(posedge CLOCK);
		chk("toggle gap", 32'd32, u_load.gap_1);
		acc(1'b0, ad(`CDT_IDX_STAT1), 32'h0000_0043);
		acc(1'b1, ad(`CDT_IDX_CTRL1), 32'h0000_0000);
		acc(1'b1, ad(`CDT_IDX_STAT1), 32'h0000_0003);
		acc(1'b0, ad(`CDT_IDX_STAT1), 32'h0000_0003);
		// Chained: A at 0x0005 sets high and clears, B at 0x0001 sets low; lower clear on B must be ignored
		acc(1'b1, ad(`CDT_IDX_CNT0), 32'h0000_0000);
		acc(1'b1, ad(`CDT_IDX_CNT1), 32'h0000_0000);
		acc(1'b1, ad(`CDT_IDX_CMPA0), 32'h0000_0000);
		acc(1'b1, ad(`CDT_IDX_CMPA1), 32'h0000_0005);
		acc(1'b1, ad(`CDT_IDX_CMPB0), 32'h0000_0000);
		acc(1'b1, ad(`CDT_IDX_CMPB1), 32'h0000_0001);
		acc(1'b1, ad(`CDT_IDX_STAT0), 32'h0000_0006);
		acc(1'b1, ad(`CDT_IDX_CTRL0), 32'h0000_000c);
		acc(1'b1, ad(`CDT_IDX_CCTL1), 32'h0000_0001);
		acc(1'b1, ad(`CDT_IDX_CTRL1), 32'h0000_0011);
		repeat (200) @(posedge CLOCK);
		chk("pin 0 high", 32'd4, u_load.high_0);
		chk("pin 0 low", 32'd8, u_load.low_0);
		chk("pin 1 gap", 32'd12, u_load.gap_1);
		acc(1'b0, ad(`CDT_IDX_STAT0), 32'h0000_00c6);
		// Lower wrap from 0xfe advances the upper byte exactly once
		acc(1'b1, ad(`CDT_IDX_CTRL1), 32'h0000_0000);
		acc(1'b1, ad(`CDT_IDX_CTRL0), 32'h0000_0004);
		acc(1'b1, ad(`CDT_IDX_CNT0), 32'h0000_0000);
		acc(1'b1, ad(`CDT_IDX_CNT1), 32'h0000_00fe);
		acc(1'b1, ad(`CDT_IDX_CTRL1), 32'h0000_0001);
		repeat (20) @(posedge CLOCK);
		acc(1'b1, ad(`CDT_IDX_CTRL1), 32'h0000_0000);
		acc(1'b0, ad(`CDT_IDX_CNT0), 32'h0000_0001);
		// External reset level holds the lower counter at zero; leave chained mode first
		acc(1'b1, ad(`CDT_IDX_CTRL0), 32'h0000_0000);
		acc(1'b1, ad(`CDT_IDX_CCTL1), 32'h0000_0005);
		acc(1'b1, ad(`CDT_IDX_CTRL1), 32'h0000_0019);
		ext_req <= 1'b1;
		repeat (10) @(posedge CLOCK);
		acc(1'b0, ad(`CDT_IDX_CNT1), 32'h0000_0000);
		ext_req <= 1'b0;
		end_of_test();
	end
endmodule
